// File: rtl/switch_node_config_bank.sv
/*
 * configuration register bank of a switch node, reached by
 * configuration read and write messages by register number.
 * assumes requests, route lookups and link answers on CORE_CLK;
 * boot strap pins are asynchronous and synchronised here.
 */
//
// Contract
// - access only by config read/write, register number
// - ident: chip id, straps, revision, version
// - description: links, cores, links per processor
// - write lock bit 31 rejects every write
// - pll lock bit 8 ignores pll writes
// - bit 0 selects one-byte headers, resets zero
// - 16-bit node id, compared msb first
// - a pll write with both write lock and pll lock clear resets the tile
// - pll fields reset from strap pins
// - switch clock is pll over divider plus one
// - reference clock divider resets to three
// - low table: mismatch bits 7..0
// - high table: mismatch bits 15..8
// - route by highest mismatching bit's direction
// - decode debug and link register groups
`timescale 1ns/1ns
module switch_node_config_bank #(
    parameter logic [7:0] CHIP_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] XBAR_REVISION = 8'h01, // arbitrary value
    parameter logic [7:0] XBAR_VERSION = 8'h01, // arbitrary value
    parameter logic [7:0] NUM_LINKS = 8'h08,
    parameter logic [7:0] NUM_CORES = 8'h01,
    parameter logic [7:0] LINKS_PER_CORE = 8'h04
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic BOOT_STRAP_PIN_A,
    input wire logic BOOT_STRAP_PIN_B,
    input wire logic CFG_REQ,
    input wire logic CFG_WRITE,
    input wire logic [7:0] CFG_REG_NUM,
    input wire logic [31:0] CFG_WDATA,
    output logic CFG_READY,
    output logic CFG_ACK,
    output logic CFG_NACK,
    output logic [31:0] CFG_RDATA,
    output logic LINK_REQ,
    output logic LINK_WRITE,
    output logic [7:0] LINK_REG_NUM,
    output logic [31:0] LINK_WDATA,
    input wire logic [31:0] LINK_RDATA,
    input wire logic DEBUG_SRC_PIN,
    input wire logic DEBUG_SRC_TILE,
    output logic DEBUG_PULLDOWN_EN,
    output logic DEBUG_DCALL_EN,
    output logic HEADER_MODE_1BYTE,
    output logic [15:0] NODE_ID,
    output logic [2:0] PLL_OUTPUT_DIVIDER,
    output logic [12:0] PLL_FEEDBACK,
    output logic [6:0] PLL_INPUT_DIVIDER,
    output logic TILE_RESET,
    output logic SWITCH_CLK_TICK,
    output logic REF_CLK_TICK,
    input wire logic ROUTE_VALID,
    input wire logic [15:0] ROUTE_DEST_ID,
    output logic ROUTE_DONE,
    output logic ROUTE_LOCAL,
    output logic [3:0] ROUTE_DIR
);
    logic [1:0] strap_meta_q;
    logic [1:0] strap_sync_q;
    logic [1:0] strap_q;
    node_cfg_pkg::boot_state_t boot_q;
    logic [31:0] sec_q;
    logic [15:0] node_id_q;
    logic [31:0] pll_q;
    logic [15:0] xbar_div_q;
    logic [15:0] ref_div_q;
    logic [31:0] dirs_lo_q;
    logic [31:0] dirs_hi_q;
    logic [31:0] dbg_pin_q;
    logic tile_reset_q;
    logic ack_q;
    logic nack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic link_req_q;
    logic link_write_q;
    logic [7:0] link_reg_q;
    logic [31:0] link_wdata_q;
    logic take;
    logic is_link;
    logic is_ro;
    logic is_rw;
    logic write_lock;
    logic pll_lock;
    logic wr_ok;
    logic link_take;
    logic [3:0] route_dir_d;
    logic route_local_d;
    logic route_done_q;
    logic route_local_q;
    logic [3:0] route_dir_q;

    // strap synchroniser and boot capture
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            strap_meta_q <= 2'h0;
            strap_sync_q <= 2'h0;
        end
        else
        begin
            strap_meta_q <= {BOOT_STRAP_PIN_B, BOOT_STRAP_PIN_A};
            strap_sync_q <= strap_meta_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            boot_q <= node_cfg_pkg::BOOT_SYNC;
        end
        else
        begin
            unique case (boot_q)
                node_cfg_pkg::BOOT_SYNC: boot_q <= node_cfg_pkg::BOOT_WAIT;
                node_cfg_pkg::BOOT_WAIT: boot_q <= node_cfg_pkg::BOOT_LATCH;
                node_cfg_pkg::BOOT_LATCH: boot_q <= node_cfg_pkg::BOOT_RUN;
                node_cfg_pkg::BOOT_RUN: boot_q <= node_cfg_pkg::BOOT_RUN;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            strap_q <= 2'h0;
        end
        else if (boot_q == node_cfg_pkg::BOOT_LATCH)
        begin
            strap_q <= strap_sync_q;
        end
    end

    // request decode
    assign CFG_READY = (boot_q == node_cfg_pkg::BOOT_RUN) && !link_req_q;
    assign take = CFG_REQ && CFG_READY;
    assign write_lock = sec_q[node_cfg_pkg::SEC_WRITE_LOCK_BIT];
    assign pll_lock = sec_q[node_cfg_pkg::SEC_PLL_LOCK_BIT];
    assign is_link =
        (CFG_REG_NUM >= node_cfg_pkg::LINK_DIR_FIRST &&
         CFG_REG_NUM <= node_cfg_pkg::LINK_DIR_LAST) ||
        (CFG_REG_NUM >= node_cfg_pkg::PLINK_FIRST &&
         CFG_REG_NUM <= node_cfg_pkg::PLINK_LAST) ||
        (CFG_REG_NUM >= node_cfg_pkg::LINK_CFG_FIRST &&
         CFG_REG_NUM <= node_cfg_pkg::LINK_CFG_LAST) ||
        (CFG_REG_NUM >= node_cfg_pkg::LINK_STATIC_FIRST &&
         CFG_REG_NUM <= node_cfg_pkg::LINK_STATIC_LAST);
    assign is_ro = CFG_REG_NUM == node_cfg_pkg::REG_IDENT ||
        CFG_REG_NUM == node_cfg_pkg::REG_DESC ||
        CFG_REG_NUM == node_cfg_pkg::REG_DBG_SRC;
    assign is_rw = CFG_REG_NUM == node_cfg_pkg::REG_SECURITY ||
        CFG_REG_NUM == node_cfg_pkg::REG_NODE_ID ||
        CFG_REG_NUM == node_cfg_pkg::REG_PLL ||
        CFG_REG_NUM == node_cfg_pkg::REG_XBAR_DIV ||
        CFG_REG_NUM == node_cfg_pkg::REG_REF_DIV ||
        CFG_REG_NUM == node_cfg_pkg::REG_DIRS_LO ||
        CFG_REG_NUM == node_cfg_pkg::REG_DIRS_HI ||
        CFG_REG_NUM == node_cfg_pkg::REG_DBG_PIN;
    assign wr_ok = take && CFG_WRITE && !write_lock;
    assign link_take = take && is_link && !(CFG_WRITE && write_lock);

    // writable registers
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sec_q <= node_cfg_pkg::SEC_RST;
            node_id_q <= node_cfg_pkg::NODE_ID_RST;
            xbar_div_q <= node_cfg_pkg::XBAR_DIV_RST;
            ref_div_q <= node_cfg_pkg::REF_DIV_RST;
            dirs_lo_q <= node_cfg_pkg::DIRS_RST;
            dirs_hi_q <= node_cfg_pkg::DIRS_RST;
            dbg_pin_q <= 32'h0000_0000;
        end
        else if (wr_ok)
        begin
            unique case (CFG_REG_NUM)
                node_cfg_pkg::REG_SECURITY:
                    sec_q <= CFG_WDATA & node_cfg_pkg::SEC_MASK;
                node_cfg_pkg::REG_NODE_ID:
                    node_id_q <= CFG_WDATA[15:0];
                node_cfg_pkg::REG_XBAR_DIV:
                    xbar_div_q <= CFG_WDATA[15:0];
                node_cfg_pkg::REG_REF_DIV:
                    ref_div_q <= CFG_WDATA[15:0];
                node_cfg_pkg::REG_DIRS_LO:
                    dirs_lo_q <= CFG_WDATA;
                node_cfg_pkg::REG_DIRS_HI:
                    dirs_hi_q <= CFG_WDATA;
                node_cfg_pkg::REG_DBG_PIN:
                    dbg_pin_q <= CFG_WDATA & node_cfg_pkg::DBG_PIN_MASK;
                default:
                    dbg_pin_q <= dbg_pin_q;
            endcase
        end
    end

    // pll settings and tile reset
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pll_q <= 32'h0000_0000;
            tile_reset_q <= 1'b0;
        end
        else if (boot_q == node_cfg_pkg::BOOT_LATCH)
        begin
            pll_q <= node_cfg_pkg::pll_reset_value(strap_sync_q);
            tile_reset_q <= 1'b0;
        end
        else if (wr_ok && !pll_lock && CFG_REG_NUM == node_cfg_pkg::REG_PLL)
        begin
            pll_q <= CFG_WDATA & node_cfg_pkg::PLL_MASK;
            tile_reset_q <= 1'b1;
        end
        else
        begin
            tile_reset_q <= 1'b0;
        end
    end

    // read mux
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (link_req_q)
        begin
            rdata_d = LINK_RDATA;
        end
        else
        begin
            unique case (CFG_REG_NUM)
                node_cfg_pkg::REG_IDENT: rdata_d = {CHIP_ID, 6'h00, strap_q,
                    XBAR_REVISION, XBAR_VERSION};
                node_cfg_pkg::REG_DESC: rdata_d = {8'h00, NUM_LINKS,
                    NUM_CORES, LINKS_PER_CORE};
                node_cfg_pkg::REG_SECURITY: rdata_d = sec_q;
                node_cfg_pkg::REG_NODE_ID: rdata_d = {16'h0000, node_id_q};
                node_cfg_pkg::REG_PLL: rdata_d = pll_q;
                node_cfg_pkg::REG_XBAR_DIV: rdata_d = {16'h0000, xbar_div_q};
                node_cfg_pkg::REG_REF_DIV: rdata_d = {16'h0000, ref_div_q};
                node_cfg_pkg::REG_DIRS_LO: rdata_d = dirs_lo_q;
                node_cfg_pkg::REG_DIRS_HI: rdata_d = dirs_hi_q;
                node_cfg_pkg::REG_DBG_PIN: rdata_d = dbg_pin_q;
                node_cfg_pkg::REG_DBG_SRC: rdata_d = {27'h0000000,
                    DEBUG_SRC_PIN, 3'h0, DEBUG_SRC_TILE};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // answer
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ack_q <= 1'b0;
            nack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= (take && !link_take) || link_req_q;
            nack_q <= take && !link_req_q && ((!is_link && !is_ro && !is_rw)
                || (CFG_WRITE && (write_lock || is_ro ||
                (pll_lock && CFG_REG_NUM == node_cfg_pkg::REG_PLL))));
            rdata_q <= ((take && CFG_WRITE) || link_write_q) ?
                32'h0000_0000 : rdata_d;
        end
    end

    // forward to link register groups
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            link_req_q <= 1'b0;
            link_write_q <= 1'b0;
            link_reg_q <= 8'h00;
            link_wdata_q <= 32'h0000_0000;
        end
        else
        begin
            link_req_q <= link_take;
            link_write_q <= link_take && CFG_WRITE;
            if (link_take)
            begin
                link_reg_q <= CFG_REG_NUM;
                link_wdata_q <= CFG_WDATA;
            end
        end
    end

    // route lookup
    route_select u_route (
        .node_id(node_id_q),
        .dest_id(ROUTE_DEST_ID),
        .dirs_lo(dirs_lo_q),
        .dirs_hi(dirs_hi_q),
        .dir(route_dir_d),
        .local_hit(route_local_d)
    );

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            route_done_q <= 1'b0;
            route_local_q <= 1'b0;
            route_dir_q <= 4'h0;
        end
        else
        begin
            route_done_q <= ROUTE_VALID;
            if (ROUTE_VALID)
            begin
                route_local_q <= route_local_d;
                route_dir_q <= route_local_d ? 4'h0 : route_dir_d;
            end
        end
    end

    clk_tick_divider #(.W(node_cfg_pkg::DIV_W)) u_xbar_div (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .divisor_m1(xbar_div_q),
        .tick(SWITCH_CLK_TICK)
    );

    clk_tick_divider #(.W(node_cfg_pkg::DIV_W)) u_ref_div (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .divisor_m1(ref_div_q),
        .tick(REF_CLK_TICK)
    );

    assign CFG_ACK = ack_q;
    assign CFG_NACK = nack_q;
    assign CFG_RDATA = rdata_q;
    assign LINK_REQ = link_req_q;
    assign LINK_WRITE = link_write_q;
    assign LINK_REG_NUM = link_reg_q;
    assign LINK_WDATA = link_wdata_q;
    assign DEBUG_PULLDOWN_EN = dbg_pin_q[0];
    assign DEBUG_DCALL_EN = dbg_pin_q[1];
    assign HEADER_MODE_1BYTE = sec_q[node_cfg_pkg::SEC_HEADER_BIT];
    assign NODE_ID = node_id_q;
    assign PLL_OUTPUT_DIVIDER = pll_q[node_cfg_pkg::PLL_OD_LSB +: 3];
    assign PLL_FEEDBACK = pll_q[node_cfg_pkg::PLL_F_LSB +: 13];
    assign PLL_INPUT_DIVIDER = pll_q[node_cfg_pkg::PLL_R_LSB +: 7];
    assign TILE_RESET = tile_reset_q;
    assign ROUTE_DONE = route_done_q;
    assign ROUTE_LOCAL = route_local_q;
    assign ROUTE_DIR = route_dir_q;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    write_lock_a: assert property (
        take && CFG_WRITE && write_lock |=> CFG_NACK && $stable(node_id_q)
        && $stable(sec_q) && !LINK_REQ)
    else $error("write passed the write lock");
    pll_lock_a: assert property (
        wr_ok && pll_lock && CFG_REG_NUM == node_cfg_pkg::REG_PLL
        |=> $stable(pll_q) && !TILE_RESET)
    else $error("pll changed while locked");
    tile_reset_a: assert property (
        wr_ok && !pll_lock && CFG_REG_NUM == node_cfg_pkg::REG_PLL
        |=> TILE_RESET ##1 !TILE_RESET)
    else $error("pll write without one tile reset pulse");
    node_id_a: assert property (
        wr_ok && CFG_REG_NUM == node_cfg_pkg::REG_NODE_ID
        |=> NODE_ID == $past(CFG_WDATA[15:0]))
    else $error("node id not written");
    header_mode_a: assert property (
        wr_ok && CFG_REG_NUM == node_cfg_pkg::REG_SECURITY
        |=> HEADER_MODE_1BYTE == $past(CFG_WDATA[0]))
    else $error("header mode not taken");
    ident_read_a: assert property (
        take && !CFG_WRITE && CFG_REG_NUM == node_cfg_pkg::REG_IDENT
        |=> CFG_RDATA == {CHIP_ID, 6'h00, strap_q, XBAR_REVISION,
        XBAR_VERSION})
    else $error("ident read wrong");
    desc_read_a: assert property (
        take && !CFG_WRITE && CFG_REG_NUM == node_cfg_pkg::REG_DESC
        |=> CFG_RDATA[31:24] == 8'h00 && CFG_RDATA[23:16] == NUM_LINKS)
    else $error("description read wrong");
    reserved_zero_a: assert property (
        take && !CFG_WRITE && CFG_REG_NUM == node_cfg_pkg::REG_REF_DIV
        |=> CFG_RDATA[31:16] == 16'h0000)
    else $error("reserved bits not zero");
    answer_time_a: assert property (
        take |-> ##[1:2] CFG_ACK)
    else $error("request left unanswered");
    link_forward_a: assert property (
        link_take |=> LINK_REQ && LINK_REG_NUM == $past(CFG_REG_NUM)
        ##1 CFG_ACK)
    else $error("link group access not forwarded");
    pll_strap_a: assert property (
        boot_q == node_cfg_pkg::BOOT_LATCH
        |=> pll_q == node_cfg_pkg::pll_reset_value(strap_q))
    else $error("pll reset value not from straps");
    route_local_a: assert property (
        ROUTE_VALID && ROUTE_DEST_ID == NODE_ID |=> ROUTE_DONE && ROUTE_LOCAL)
    else $error("local packet not delivered locally");
    route_high_a: assert property (
        ROUTE_VALID && ROUTE_DEST_ID[15] != NODE_ID[15]
        |=> ROUTE_DIR == $past(dirs_hi_q[31:28]) && !ROUTE_LOCAL)
    else $error("bit 15 mismatch routed wrong");
    route_low_a: assert property (
        ROUTE_VALID && ROUTE_DEST_ID[15:8] == NODE_ID[15:8]
        && ROUTE_DEST_ID[7] != NODE_ID[7]
        |=> ROUTE_DIR == $past(dirs_lo_q[31:28]))
    else $error("bit 7 mismatch routed wrong");

endmodule : switch_node_config_bank

// File: common/node_cfg_pkg.sv
/*
 * shared constants of the switch node configuration bank:
 * register numbers, field masks, reset values, boot states.
 * assumes one switch clock domain for every user.
 */
package node_cfg_pkg;

    localparam logic [7:0] REG_IDENT = 8'h00;
    localparam logic [7:0] REG_DESC = 8'h01;
    localparam logic [7:0] REG_SECURITY = 8'h04;
    localparam logic [7:0] REG_NODE_ID = 8'h05;
    localparam logic [7:0] REG_PLL = 8'h06;
    localparam logic [7:0] REG_XBAR_DIV = 8'h07;
    localparam logic [7:0] REG_REF_DIV = 8'h08;
    localparam logic [7:0] REG_DIRS_LO = 8'h0C;
    localparam logic [7:0] REG_DIRS_HI = 8'h0D;
    localparam logic [7:0] REG_DBG_PIN = 8'h10;
    localparam logic [7:0] REG_DBG_SRC = 8'h1F;

    localparam logic [7:0] LINK_DIR_FIRST = 8'h20;
    localparam logic [7:0] LINK_DIR_LAST = 8'h27;
    localparam logic [7:0] PLINK_FIRST = 8'h40;
    localparam logic [7:0] PLINK_LAST = 8'h43;
    localparam logic [7:0] LINK_CFG_FIRST = 8'h80;
    localparam logic [7:0] LINK_CFG_LAST = 8'h87;
    localparam logic [7:0] LINK_STATIC_FIRST = 8'hA0;
    localparam logic [7:0] LINK_STATIC_LAST = 8'hA7;

    localparam int SEC_WRITE_LOCK_BIT = 31;
    localparam int SEC_PLL_LOCK_BIT = 8;
    localparam int SEC_HEADER_BIT = 0;
    localparam logic [31:0] SEC_MASK = 32'h8000_0101;
    localparam logic [31:0] SEC_RST = 32'h0000_0000;

    localparam int NODE_ID_W = 16;
    localparam int DIR_W = 4;
    localparam int DIV_W = 16;
    localparam logic [15:0] NODE_ID_RST = 16'h0000;
    localparam logic [15:0] XBAR_DIV_RST = 16'h0000;
    localparam logic [15:0] REF_DIV_RST = 16'h0003;
    localparam logic [31:0] DIRS_RST = 32'h0000_0000;

    localparam int PLL_OD_W = 3;
    localparam int PLL_F_W = 13;
    localparam int PLL_R_W = 7;
    localparam int PLL_OD_LSB = 23;
    localparam int PLL_F_LSB = 8;
    localparam int PLL_R_LSB = 0;
    localparam logic [31:0] PLL_MASK = 32'h039F_FF7F;
    localparam logic [31:0] DBG_PIN_MASK = 32'h0000_0003;

    typedef enum logic [1:0] {
        BOOT_SYNC = 2'b00,
        BOOT_WAIT = 2'b01,
        BOOT_LATCH = 2'b11,
        BOOT_RUN = 2'b10
    } boot_state_t;

    // pll reset word per strap pair {pin_b, pin_a}
    function automatic logic [31:0] pll_reset_value(input logic [1:0] strap);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (strap)
            2'b00: v = 32'h0080_6301;
            2'b01: v = 32'h0080_C701;
            2'b10: v = 32'h0100_6301;
            2'b11: v = 32'h0100_C701;
        endcase
        return v;
    endfunction : pll_reset_value

endpackage : node_cfg_pkg

// File: rtl/clk_tick_divider.sv
/*
 * divides the clock by divisor plus one and emits one tick per period.
 * assumes the divisor is a same-domain register.
 */
`timescale 1ns/1ns
module clk_tick_divider #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] divisor_m1,
    output logic tick
);
    logic [W-1:0] count_q;
    logic tick_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= '0;
            tick_q <= 1'b0;
        end
        else if (count_q >= divisor_m1)
        begin
            count_q <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            count_q <= count_q + W'(1);
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;

    tick_spacing_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        tick_q && divisor_m1 != '0 && $stable(divisor_m1) |=> !tick_q)
    else $error("divider ticked twice in a row");

endmodule : clk_tick_divider

// File: rtl/route_select.sv
/*
 * picks a route direction from the highest bit where destination
 * and node id differ; flags local delivery on a full match.
 * assumes both tables are register outputs of the same domain.
 */
`timescale 1ns/1ns
module route_select (
    input wire logic [node_cfg_pkg::NODE_ID_W-1:0] node_id,
    input wire logic [node_cfg_pkg::NODE_ID_W-1:0] dest_id,
    input wire logic [31:0] dirs_lo,
    input wire logic [31:0] dirs_hi,
    output logic [node_cfg_pkg::DIR_W-1:0] dir,
    output logic local_hit
);
    logic [node_cfg_pkg::NODE_ID_W-1:0] diff;
    logic [63:0] table_all;

    assign diff = node_id ^ dest_id;
    assign table_all = {dirs_hi, dirs_lo};
    assign local_hit = (diff == '0);

    // lowest set bit first so the highest mismatch wins
    always_comb
    begin
        dir = '0;
        for (int i = 0; i < node_cfg_pkg::NODE_ID_W; i++)
        begin
            if (diff[i])
            begin
                dir = table_all[i*node_cfg_pkg::DIR_W +: node_cfg_pkg::DIR_W];
            end
        end
    end

endmodule : route_select

// File: bench/link_group_model.sv
/*
 * answers forwarded link-group reads of the bank.
 * assumes read data is sampled in the LINK_REQ cycle.
 */
`timescale 1ns/1ns
module link_group_model (
    input wire logic clk,
    input wire logic link_req,
    input wire logic [7:0] link_reg_num,
    output logic [31:0] link_rdata
);
    logic [15:0] idle_q = 16'h0000;
    // changing pattern while not addressed
    always @(posedge clk)
    begin
        idle_q <= idle_q + 16'h0001;
    end
    assign link_rdata = link_req ? {16'hC0DE, 8'h00, link_reg_num}
        : {16'h0000, idle_q};
endmodule : link_group_model

// File: bench/switch_node_config_bank_test.sv
/*
 * self-checking bench of the switch node configuration bank.
 * assumes a 20 MHz clock and a link-group model on the far side.
 */
`timescale 1ns/1ns
module switch_node_config_bank_test;
    typedef struct packed {
        logic w;
        logic [7:0] n;
        logic [31:0] d;
        logic nk;
        logic [31:0] rd;
    } row_t;
    logic CORE_CLK = 0, RESET_N = 0, BOOT_STRAP_PIN_A = 1;
    logic BOOT_STRAP_PIN_B = 0, CFG_REQ = 0, CFG_WRITE = 0;
    logic [7:0] CFG_REG_NUM = 0;
    logic [31:0] CFG_WDATA = 0, CFG_RDATA, LINK_RDATA;
    logic CFG_READY, CFG_ACK, CFG_NACK, LINK_REQ, TILE_RESET;
    logic [7:0] LINK_REG_NUM;
    logic DEBUG_PULLDOWN_EN, DEBUG_DCALL_EN, HEADER_MODE_1BYTE;
    logic [15:0] NODE_ID, ROUTE_DEST_ID = 0;
    logic SWITCH_CLK_TICK, REF_CLK_TICK, ROUTE_VALID = 0;
    logic ROUTE_DONE, ROUTE_LOCAL;
    logic [3:0] ROUTE_DIR;
    logic [2:0] PLL_OUTPUT_DIVIDER;
    logic [12:0] PLL_FEEDBACK;
    logic [6:0] PLL_INPUT_DIVIDER;
    logic LINK_WRITE;
    logic [31:0] LINK_WDATA;
    logic [31:0] link_seen = 0;
    int failures = 0, tests_run = 0, cycles = 0, sw, rf;
    row_t rows [0:24] = '{
        {1'b0, 8'h00, 32'h0, 1'b0, 32'h5A01_0101},
        {1'b0, 8'h01, 32'h0, 1'b0, 32'h0008_0104},
        {1'b0, 8'h04, 32'h0, 1'b0, 32'h0},
        {1'b0, 8'h05, 32'h0, 1'b0, 32'h0},
        {1'b0, 8'h06, 32'h0, 1'b0, 32'h0080_C701},
        {1'b0, 8'h07, 32'h0, 1'b0, 32'h0},
        {1'b0, 8'h08, 32'h0, 1'b0, 32'h3},
        {1'b0, 8'h0C, 32'h0, 1'b0, 32'h0},
        {1'b0, 8'h0D, 32'h0, 1'b0, 32'h0},
        {1'b1, 8'h05, 32'hFFFF_1234, 1'b0, 32'h0},
        {1'b0, 8'h05, 32'h0, 1'b0, 32'h0000_1234},
        {1'b1, 8'h00, 32'h1, 1'b1, 32'h0},
        {1'b1, 8'h01, 32'h1, 1'b1, 32'h0},
        {1'b1, 8'h1F, 32'h1, 1'b1, 32'h0},
        {1'b0, 8'h1F, 32'h0, 1'b0, 32'h0000_0010},
        {1'b0, 8'h02, 32'h0, 1'b1, 32'h0},
        {1'b1, 8'h0C, 32'h7654_3210, 1'b0, 32'h0},
        {1'b1, 8'h0D, 32'hFEDC_BA98, 1'b0, 32'h0},
        {1'b1, 8'h07, 32'h0001_0001, 1'b0, 32'h0},
        {1'b1, 8'h08, 32'h0, 1'b0, 32'h0},
        {1'b1, 8'h06, 32'hFFFF_FFFF, 1'b0, 32'h0},
        {1'b0, 8'h06, 32'h0, 1'b0, 32'h039F_FF7F},
        {1'b1, 8'h10, 32'hFF, 1'b0, 32'h0},
        {1'b0, 8'h43, 32'h0, 1'b0, 32'hC0DE_0043},
        {1'b1, 8'h80, 32'hA5A5_0001, 1'b0, 32'h0}
    };
    switch_node_config_bank uut (.CORE_CLK, .RESET_N, .BOOT_STRAP_PIN_A,
        .BOOT_STRAP_PIN_B, .CFG_REQ, .CFG_WRITE, .CFG_REG_NUM, .CFG_WDATA,
        .CFG_READY, .CFG_ACK, .CFG_NACK, .CFG_RDATA, .LINK_REQ,
        .LINK_WRITE, .LINK_REG_NUM, .LINK_WDATA, .LINK_RDATA,
        .DEBUG_SRC_PIN(1'b1), .DEBUG_SRC_TILE(1'b0), .DEBUG_PULLDOWN_EN,
        .DEBUG_DCALL_EN, .HEADER_MODE_1BYTE, .NODE_ID,
        .PLL_OUTPUT_DIVIDER, .PLL_FEEDBACK, .PLL_INPUT_DIVIDER,
        .TILE_RESET, .SWITCH_CLK_TICK, .REF_CLK_TICK, .ROUTE_VALID,
        .ROUTE_DEST_ID, .ROUTE_DONE, .ROUTE_LOCAL, .ROUTE_DIR);
    link_group_model far (.clk(CORE_CLK), .link_req(LINK_REQ),
        .link_reg_num(LINK_REG_NUM), .link_rdata(LINK_RDATA));
    initial
    begin
        forever #25 CORE_CLK = ~CORE_CLK;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    task cfg(input row_t r);
        int i;
        {CFG_REQ, CFG_WRITE, CFG_REG_NUM, CFG_WDATA} = {1'b1, r.w, r.n, r.d};
        i = 0;
        @(negedge CORE_CLK);
        while (CFG_READY !== 1'b1 && i < 8)
        begin
            @(negedge CORE_CLK);
            i++;
        end
        @(posedge CORE_CLK);
        #2 CFG_REQ = 0;
        i = 0;
        @(negedge CORE_CLK);
        while (CFG_ACK !== 1'b1 && i < 4)
        begin
            @(negedge CORE_CLK);
            i++;
        end
        check(CFG_ACK, 1);
        check(CFG_NACK, r.nk);
        check(CFG_RDATA, r.rd);
        check(TILE_RESET, r.w && r.n == 8'h06 && !r.nk);
        @(posedge CORE_CLK);
        #2;
    endtask : cfg
    task route(input logic [15:0] dest, input logic loc, input logic [3:0] dir);
        {ROUTE_VALID, ROUTE_DEST_ID} = {1'b1, dest};
        @(posedge CORE_CLK);
        #2 ROUTE_VALID = 0;
        @(negedge CORE_CLK);
        check(ROUTE_DONE, 1);
        check(ROUTE_LOCAL, loc);
        check(ROUTE_DIR, dir);
        @(posedge CORE_CLK);
        #2;
    endtask : route
    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            give_verdict();
        end
    end
    // last forwarded link write
    always @(negedge CORE_CLK)
    begin
        if (LINK_REQ && LINK_WRITE)
            link_seen <= LINK_WDATA;
    end
    initial
    begin
        repeat (5) @(posedge CORE_CLK);
        #2 RESET_N = 1;
        foreach (rows[k])
            cfg(rows[k]);
        check(NODE_ID, 16'h1234);
        check({DEBUG_PULLDOWN_EN, DEBUG_DCALL_EN}, 2'b11);
        check(link_seen, 32'hA5A5_0001);
        check({PLL_OUTPUT_DIVIDER, PLL_FEEDBACK, PLL_INPUT_DIVIDER},
            {3'h7, 13'h1FFF, 7'h7F});
        for (int n = 0; n < 16; n++)
            route(16'h1234 ^ (16'hFFFF >> (15 - n)), 0, n[3:0]);
        route(16'h1234, 1, 0);
        {sw, rf} = 0;
        repeat (20) @(negedge CORE_CLK)
        begin
            sw += SWITCH_CLK_TICK;
            rf += REF_CLK_TICK;
        end
        check(sw, 10);
        check(rf, 20);
        cfg({1'b1, 8'h04, 32'h7FFF_FE01, 1'b0, 32'h0});
        check(HEADER_MODE_1BYTE, 1);
        cfg({1'b0, 8'h04, 32'h0, 1'b0, 32'h0000_0001});
        cfg({1'b1, 8'h04, 32'h0000_0101, 1'b0, 32'h0});
        check(HEADER_MODE_1BYTE, 1);
        cfg({1'b1, 8'h06, 32'h0, 1'b1, 32'h0});
        cfg({1'b0, 8'h06, 32'h0, 1'b0, 32'h039F_FF7F});
        cfg({1'b1, 8'h04, 32'h8000_0101, 1'b0, 32'h0});
        cfg({1'b1, 8'h05, 32'h0, 1'b1, 32'h0});
        cfg({1'b1, 8'h20, 32'h0, 1'b1, 32'h0});
        cfg({1'b0, 8'h04, 32'h0, 1'b0, 32'h8000_0101});
        cfg({1'b0, 8'h20, 32'h0, 1'b0, 32'hC0DE_0020});
        RESET_N = 0;
        BOOT_STRAP_PIN_B = 1;
        repeat (5) @(posedge CORE_CLK);
        #2 RESET_N = 1;
        cfg({1'b0, 8'h00, 32'h0, 1'b0, 32'h5A03_0101});
        cfg({1'b0, 8'h06, 32'h0, 1'b0, 32'h0100_C701});
        check({PLL_OUTPUT_DIVIDER, PLL_FEEDBACK, PLL_INPUT_DIVIDER},
            {3'h2, 13'h00C7, 7'h01});
        cfg({1'b0, 8'h04, 32'h0, 1'b0, 32'h0});
        give_verdict();
    end
endmodule : switch_node_config_bank_test
